// ==== design/disk_type_defines.svh ====
`ifndef DISK_TYPE_DEFINES_SVH
`define DISK_TYPE_DEFINES_SVH
// Disk type codes as entered on the keypad
`define DT_CODE_REMOVABLE 8'h00
`define DT_CODE_LOCAL     8'h01
// Factory default disk type: local
`define DT_RESET_LOCAL    1'b1
// Digit that selects the disk type command
`define DT_CMD_DIGIT      4'h8
// Timing
`define CLK_HZ            200000000
`define PHASE_MS          1000
`define BLINK_MS          250
`define HOLD_MS           1000
`define PHASE_CYC         ((`CLK_HZ / 1000) * `PHASE_MS)
`define BLINK_CYC         ((`CLK_HZ / 1000) * `BLINK_MS)
`define HOLD_CYC          ((`CLK_HZ / 1000) * `HOLD_MS)
`endif

// ==== design/disk_type_pkg.sv ====
package disk_type_pkg;
    // Debounced-free keypad event bundle, one pulse per press edge
    typedef struct packed {
        logic       keyDn;
        logic       shiftDn;
        logic       digitDn;
        logic [3:0] digit;
    } key_evt_t;
    // LED drive triple
    typedef struct packed {
        logic red;
        logic green;
        logic blue;
    } led_t;
    // Gray codes along select path idle->select->digits->commit
    typedef enum logic [3:0] {
        ST_LOCKED  = 4'h0,
        ST_ADMIN   = 4'h1,
        ST_SELECT  = 4'h3,
        ST_DIGIT2  = 4'h2,
        ST_CONFIRM = 4'h6,
        ST_RESET   = 4'h7,
        ST_QWAIT   = 4'h5,
        ST_SHOW    = 4'h4,
        ST_UNLOCK  = 4'hC
    } dt_state_t;
endpackage : disk_type_pkg

// ==== design/key_sync.sv ====
`timescale 1ns/1ps
`default_nettype none
// Two-flop sync of raw buttons, then press-edge pulses
module key_sync (
    input  wire logic        ref_clk,
    input  wire logic        rst_n,
    input  wire logic        keyRaw,
    input  wire logic        shiftRaw,
    input  wire logic [9:0]  digitRaw,
    output disk_type_pkg::key_evt_t evt,
    output logic             keyLvl,
    output logic             shiftLvl,
    output logic [9:0]       digitLvl
);
    logic [11:0] meta_ff;
    logic [11:0] sync_ff;
    logic [11:0] prev_ff;
    logic [11:0] rise;
    logic [3:0]  idx;

    // Synchroniser; first stage read only by second
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            meta_ff <= 12'h000;
            sync_ff <= 12'h000;
            prev_ff <= 12'h000;
        end else begin
            meta_ff <= {keyRaw, shiftRaw, digitRaw};
            sync_ff <= meta_ff;
            prev_ff <= sync_ff;
        end
    end

    assign rise = sync_ff & ~prev_ff;
    // Lowest pressed digit wins if several rise together
    always_comb begin
        idx = 4'h0;
        for (int i = 9; i >= 0; i--) begin
            if (rise[i]) begin
                idx = 4'(i);
            end
        end
    end
    assign evt.keyDn   = rise[11];
    assign evt.shiftDn = rise[10];
    assign evt.digitDn = |rise[9:0];
    assign evt.digit   = idx;
    assign keyLvl      = sync_ff[11];
    assign shiftLvl    = sync_ff[10];
    assign digitLvl    = sync_ff[9:0];
endmodule : key_sync
`default_nettype wire

// ==== design/disk_type_ctrl.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "disk_type_defines.svh"
// Contract
// - Key plus 8 in admin starts selection
// - Two digits 00/01, green-blue keeps blinking; code holds green and blue solid instead
// - Local disk is the default setting
// - Shift commits: solid green, then solid red
// - Changed type erases PINs, key, data
// - After change refuse use until new PIN
// - Disk type commands only in admin state
// - Shift plus 8 then key requests report
// - Removable: all on, off, all on, off
// - Local: all on, green blink, all on
// - Standby red, unlock plus PIN gives green
// - Shift held one second leaves admin
module disk_type_ctrl #(
    parameter int PHASE_CYC = `PHASE_CYC,
    parameter int BLINK_CYC = `BLINK_CYC,
    parameter int HOLD_CYC  = `HOLD_CYC
) (
    input  wire logic       ref_clk,
    input  wire logic       rst_n,
    input  wire logic       keyRaw,
    input  wire logic       shiftRaw,
    input  wire logic [9:0] digitRaw,
    input  wire logic       adminEnter,
    input  wire logic       pinAccept,
    input  wire logic       adminPinSet,
    output logic            ledRed,
    output logic            ledGreen,
    output logic            ledBlue,
    output logic            diskLocal,
    output logic            eraseReq,
    output logic            usable,
    output logic            unlocked
);
    disk_type_pkg::key_evt_t  evt;
    disk_type_pkg::dt_state_t state_ff;
    disk_type_pkg::dt_state_t nxt_state;
    disk_type_pkg::led_t      led;
    logic                     keyLvl;
    logic                     shiftLvl;
    logic [9:0]               digitLvl;
    logic                     isQuery_ff;
    logic [7:0]               code_ff;
    logic [31:0]              tmr_ff;
    logic [31:0]              hold_ff;
    logic [1:0]               phase_ff;
    logic                     needPin_ff;
    logic                     local_ff;
    logic                     holdExit;
    logic                     tmrDone;

    key_sync u_sync (
        .ref_clk  (ref_clk),
        .rst_n    (rst_n),
        .keyRaw   (keyRaw),
        .shiftRaw (shiftRaw),
        .digitRaw (digitRaw),
        .evt      (evt),
        .keyLvl   (keyLvl),
        .shiftLvl (shiftLvl),
        .digitLvl (digitLvl)
    );

    // Is a code one of the two accepted disk types
    function automatic logic codeValid(input logic [7:0] c);
        return (c == `DT_CODE_REMOVABLE) || (c == `DT_CODE_LOCAL);
    endfunction : codeValid

    assign tmrDone  = (tmr_ff == 32'(PHASE_CYC - 1));
    assign holdExit = (hold_ff == 32'(HOLD_CYC - 1));

    // Shift-alone hold counter; any digit press resets it
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            hold_ff <= 32'h0000_0000;
        end else if (state_ff == disk_type_pkg::ST_ADMIN && shiftLvl && digitLvl == 10'h000
                     && !holdExit) begin
            hold_ff <= hold_ff + 32'h0000_0001;
        end else begin
            hold_ff <= 32'h0000_0000;
        end
    end

    // Next state
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            disk_type_pkg::ST_LOCKED: begin
                if (!needPin_ff && adminEnter) begin
                    nxt_state = disk_type_pkg::ST_ADMIN;
                end else if (!needPin_ff && pinAccept) begin
                    nxt_state = disk_type_pkg::ST_UNLOCK;
                end
            end
            disk_type_pkg::ST_UNLOCK: begin
                // Admin PIN while unlocked also reaches admin; else no way out
                if (adminEnter) begin
                    nxt_state = disk_type_pkg::ST_ADMIN;
                end
            end
            disk_type_pkg::ST_ADMIN: begin
                if (holdExit) begin
                    nxt_state = disk_type_pkg::ST_LOCKED;
                end else if (evt.digitDn && evt.digit == `DT_CMD_DIGIT && keyLvl) begin
                    nxt_state = disk_type_pkg::ST_SELECT;
                end else if (evt.digitDn && evt.digit == `DT_CMD_DIGIT && shiftLvl) begin
                    nxt_state = disk_type_pkg::ST_QWAIT;
                end
            end
            disk_type_pkg::ST_SELECT: begin
                if (evt.digitDn && !keyLvl) begin
                    nxt_state = disk_type_pkg::ST_DIGIT2;
                end
            end
            disk_type_pkg::ST_DIGIT2: begin
                if (evt.digitDn) begin
                    nxt_state = disk_type_pkg::ST_CONFIRM;
                end
            end
            disk_type_pkg::ST_CONFIRM: begin
                if (evt.shiftDn) begin
                    if (!codeValid(code_ff)) begin
                        nxt_state = disk_type_pkg::ST_ADMIN;
                    end else begin
                        nxt_state = disk_type_pkg::ST_RESET;
                    end
                end
            end
            disk_type_pkg::ST_RESET: begin
                if (tmrDone) begin
                    nxt_state = disk_type_pkg::ST_LOCKED;
                end
            end
            disk_type_pkg::ST_QWAIT: begin
                if (evt.keyDn) begin
                    nxt_state = disk_type_pkg::ST_SHOW;
                end
            end
            disk_type_pkg::ST_SHOW: begin
                if (tmrDone && phase_ff == 2'd3) begin
                    nxt_state = disk_type_pkg::ST_ADMIN;
                end
            end
            default: begin
                nxt_state = disk_type_pkg::ST_LOCKED;
            end
        endcase
    end

    // State register
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            state_ff <= disk_type_pkg::ST_LOCKED;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // Phase timer: one second per phase in report and commit
    always_ff @(posedge ref_clk) begin
        if (!rst_n || state_ff != nxt_state || tmrDone) begin
            tmr_ff <= 32'h0000_0000;
        end else if (state_ff == disk_type_pkg::ST_SHOW
                     || state_ff == disk_type_pkg::ST_RESET) begin
            tmr_ff <= tmr_ff + 32'h0000_0001;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n || state_ff != disk_type_pkg::ST_SHOW) begin
            phase_ff <= 2'd0;
        end else if (tmrDone) begin
            phase_ff <= phase_ff + 2'd1;
        end
    end

    // Digit shift register, tens digit first
    always_ff @(posedge ref_clk) begin
        if (!rst_n || state_ff == disk_type_pkg::ST_ADMIN) begin
            code_ff <= 8'hFF;
        end else if (evt.digitDn && ((state_ff == disk_type_pkg::ST_SELECT && !keyLvl)
                     || state_ff == disk_type_pkg::ST_DIGIT2)) begin
            code_ff <= {code_ff[3:0], evt.digit};
        end
    end

    // Setting, erase and PIN lockout; commit only on real change
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            local_ff   <= `DT_RESET_LOCAL;
            needPin_ff <= 1'b0;
            eraseReq   <= 1'b0;
        end else begin
            eraseReq <= 1'b0;
            if (state_ff == disk_type_pkg::ST_CONFIRM && evt.shiftDn && codeValid(code_ff)
                && (code_ff == `DT_CODE_LOCAL) != local_ff) begin
                local_ff   <= (code_ff == `DT_CODE_LOCAL);
                eraseReq   <= 1'b1;
                needPin_ff <= 1'b1;
            end else if (adminPinSet) begin
                needPin_ff <= 1'b0;
            end
        end
    end

    // LED pattern per state
    always_comb begin
        led = '0;
        case (state_ff)
            disk_type_pkg::ST_LOCKED:  led.red = 1'b1;
            disk_type_pkg::ST_UNLOCK:  led.green = 1'b1;
            disk_type_pkg::ST_ADMIN:   led.blue = 1'b1;
            disk_type_pkg::ST_RESET:   led.green = 1'b1;
            disk_type_pkg::ST_SHOW: begin
                if (phase_ff == 2'd0 || phase_ff == 2'd2) begin
                    led = '1;
                end else if (phase_ff == 2'd1 && local_ff) begin
                    led.green = (tmr_ff < 32'(BLINK_CYC));
                end
            end
            default: begin
                led.green = 1'b1;
                led.blue  = 1'b1;
            end
        endcase
    end

    // Registered outputs
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            ledRed    <= 1'b1;
            ledGreen  <= 1'b0;
            ledBlue   <= 1'b0;
            diskLocal <= `DT_RESET_LOCAL;
            usable    <= 1'b0;
            unlocked  <= 1'b0;
        end else begin
            ledRed    <= led.red;
            ledGreen  <= led.green;
            ledBlue   <= led.blue;
            diskLocal <= local_ff;
            usable    <= !needPin_ff;
            unlocked  <= (state_ff == disk_type_pkg::ST_UNLOCK);
        end
    end

    // Committed change always arms erase
    erase_on_change_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        $changed(local_ff) |-> eraseReq && needPin_ff)
        else $error("disk type changed without erase");
    // Invalid code never commits
    invalid_no_commit_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        state_ff == disk_type_pkg::ST_CONFIRM && evt.shiftDn && !codeValid(code_ff)
        |=> $stable(local_ff) && !eraseReq)
        else $error("invalid code changed state");
    // Lockout blocks admin entry
    pin_lockout_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        state_ff == disk_type_pkg::ST_LOCKED && needPin_ff
        |=> state_ff == disk_type_pkg::ST_LOCKED)
        else $error("use allowed before new PIN");
    // Selection only from admin
    select_from_admin_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        state_ff == disk_type_pkg::ST_SELECT && $past(state_ff) != disk_type_pkg::ST_SELECT
        |-> $past(state_ff) == disk_type_pkg::ST_ADMIN)
        else $error("selection outside admin");
    // Report starts with all LEDs lit
    report_all_on_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        state_ff == disk_type_pkg::ST_SHOW && phase_ff == 2'd0
        |=> ledRed && ledGreen && ledBlue)
        else $error("report phase not all on");
    // Local report blinks green in the gap
    local_blink_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        state_ff == disk_type_pkg::ST_SHOW && phase_ff == 2'd1 && local_ff && tmr_ff == 32'h0
        |=> ledGreen && !ledRed && !ledBlue)
        else $error("local blink missing");
    // Commit shows solid green, not red
    commit_green_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        state_ff == disk_type_pkg::ST_RESET |=> ledGreen && !ledRed)
        else $error("commit not solid green");
    // Long shift hold exits admin
    shift_exit_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        state_ff == disk_type_pkg::ST_ADMIN && holdExit |=> state_ff == disk_type_pkg::ST_LOCKED)
        else $error("shift hold did not exit");
endmodule : disk_type_ctrl
`default_nettype wire

// ==== testbench/keypad_operator.sv ====
`timescale 1ns/1ps
`default_nettype none
// Person at the keypad; buttons change only at falling edges
module keypad_operator (
    input  wire logic       ref_clk,
    output logic            keyRaw,
    output logic            shiftRaw,
    output logic [9:0]      digitRaw
);
    // All buttons released at time zero
    initial begin
        keyRaw   = 1'b0;
        shiftRaw = 1'b0;
        digitRaw = 10'h000;
    end
    // Wait whole cycles
    task automatic idle(input int n);
        repeat (n) @(negedge ref_clk);
    endtask : idle
    // Press buttons together, hold n cycles, release all together
    task automatic press(input logic k, input logic s, input int d, input int n);
        @(negedge ref_clk);
        keyRaw   = k;
        shiftRaw = s;
        if (d >= 0) begin
            digitRaw[d] = 1'b1;
        end
        idle(n);
        keyRaw   = 1'b0;
        shiftRaw = 1'b0;
        digitRaw = 10'h000;
    endtask : press
endmodule : keypad_operator
`default_nettype wire

// ==== testbench/tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic                 ref_clk;
    logic                 rst_n;
    logic                 adminEnter;
    logic                 pinAccept;
    logic                 adminPinSet;
    wire logic            keyRaw;
    wire logic            shiftRaw;
    wire logic [9:0]      digitRaw;
    logic                 ledRed;
    logic                 ledGreen;
    logic                 ledBlue;
    logic                 diskLocal;
    logic                 eraseReq;
    logic                 usable;
    logic                 unlocked;
    disk_type_pkg::led_t  leds;
    int                   errors;
    int                   cmp_count;
    int                   cycles;
    int                   erases;
    // Short counts keep the run small
    localparam int PHASE = 20;
    assign leds = {ledRed, ledGreen, ledBlue};

    initial ref_clk = 1'b0;
    always #2.5 ref_clk = ~ref_clk;

    keypad_operator u_op (.ref_clk(ref_clk), .keyRaw(keyRaw), .shiftRaw(shiftRaw),
                          .digitRaw(digitRaw));
    disk_type_ctrl #(.PHASE_CYC(PHASE), .BLINK_CYC(5), .HOLD_CYC(10)) u_disk_type_ctrl (
        .ref_clk(ref_clk), .rst_n(rst_n), .keyRaw(keyRaw), .shiftRaw(shiftRaw),
        .digitRaw(digitRaw), .adminEnter(adminEnter), .pinAccept(pinAccept),
        .adminPinSet(adminPinSet), .ledRed(ledRed), .ledGreen(ledGreen),
        .ledBlue(ledBlue), .diskLocal(diskLocal), .eraseReq(eraseReq),
        .usable(usable), .unlocked(unlocked));

    // Erase pulses counted, plus hang guard
    always @(negedge ref_clk) begin
        cycles++;
        if (eraseReq === 1'b1) erases++;
        if (cycles == 6000) begin
            errors++;
            results();
        end
    end

    task automatic results();
        $display("errors=%0d comparisons=%0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : results
    task automatic chkLed(input disk_type_pkg::led_t exp, input string msg);
        cmp_count++;
        if (leds !== exp) begin
            errors++;
            $display("CHECK FAILED %0t %s leds=%b exp=%b", $time, msg, leds, exp);
        end
    endtask : chkLed
    task automatic chkBit(input logic got, input logic exp, input string msg);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED %0t %s got=%b exp=%b", $time, msg, got, exp);
        end
    endtask : chkBit
    // Bounded wait for an LED pattern
    task automatic waitLed(input disk_type_pkg::led_t exp, input string msg);
        for (int i = 0; i < 200 && leds !== exp; i++) begin
            @(negedge ref_clk);
        end
        chkLed(exp, msg);
    endtask : waitLed
    // One-cycle pulse: 0 admin PIN, 1 unlock PIN, 2 new admin PIN
    task automatic pulse(input int sel);
        @(negedge ref_clk);
        adminEnter  = (sel == 0);
        pinAccept   = (sel == 1);
        adminPinSet = (sel == 2);
        @(negedge ref_clk);
        adminEnter  = 1'b0;
        pinAccept   = 1'b0;
        adminPinSet = 1'b0;
        u_op.idle(8);
    endtask : pulse
    // Key+8, two digits, shift
    task automatic selectCode(input int d1, input int d2);
        u_op.press(1'b1, 1'b0, 8, 6);
        waitLed(3'h3, "select shown");
        u_op.press(1'b0, 1'b0, d1, 5);
        u_op.idle(8);
        chkLed(3'h3, "first digit");
        u_op.press(1'b0, 1'b0, d2, 5);
        u_op.idle(8);
        chkLed(3'h3, "second digit");
        u_op.press(1'b0, 1'b1, -1, 5);
    endtask : selectCode
    // Report pattern; gap differs only in green
    task automatic query(input logic isLocal);
        logic sawGreen;
        sawGreen = 1'b0;
        u_op.press(1'b0, 1'b1, 8, 6);
        waitLed(3'h3, "query armed");
        u_op.press(1'b1, 1'b0, -1, 4);
        waitLed(3'h7, "report start");
        u_op.idle(10);
        chkLed(3'h7, "first all on");
        u_op.idle(12);
        for (int i = 0; i < 16; i++) begin
            chkBit(ledRed | ledBlue, 1'b0, "gap red blue");
            sawGreen |= ledGreen;
            u_op.idle(1);
        end
        chkBit(sawGreen, isLocal, "gap green");
        u_op.idle(12);
        chkLed(3'h7, "second all on");
        u_op.idle(45);
        chkLed(3'h1, "back to admin");
    endtask : query

    task automatic t_start();
        chkLed(3'h4, "standby red");
        chkBit(diskLocal, 1'b1, "default local");
        chkBit(unlocked, 1'b0, "locked");
        u_op.press(1'b1, 1'b0, 8, 6);
        u_op.idle(12);
        chkLed(3'h4, "select outside admin");
    endtask : t_start
    task automatic t_invalid();
        pulse(0);
        waitLed(3'h1, "admin blue");
        query(1'b1);
        selectCode(0, 5);
        waitLed(3'h1, "invalid back to admin");
        selectCode(2, 3);
        waitLed(3'h1, "invalid 23 back");
        selectCode(4, 6);
        waitLed(3'h1, "invalid 46 back");
        selectCode(7, 9);
        waitLed(3'h1, "invalid 79 back");
        chkBit(diskLocal, 1'b1, "invalid keeps type");
        chkBit(erases == 0, 1'b1, "invalid no erase");
    endtask : t_invalid
    task automatic t_change();
        selectCode(0, 0);
        waitLed(3'h2, "commit green");
        chkBit(erases == 1, 1'b1, "erase once");
        chkBit(diskLocal, 1'b0, "now removable");
        chkBit(usable, 1'b0, "lockout");
        waitLed(3'h4, "reset red");
        pulse(0);
        chkLed(3'h4, "admin refused");
        pulse(1);
        chkBit(unlocked, 1'b0, "unlock refused");
        pulse(2);
        chkBit(usable, 1'b1, "pin set");
        pulse(1);
        chkBit(unlocked, 1'b1, "unlock");
        chkBit(ledRed, 1'b0, "unlock not red");
    endtask : t_change
    task automatic t_removable();
        pulse(0);
        waitLed(3'h1, "admin again");
        query(1'b0);
        u_op.press(1'b0, 1'b1, -1, 20);
        waitLed(3'h4, "shift exit");
        pulse(0);
        waitLed(3'h1, "admin third");
        selectCode(0, 0);
        waitLed(3'h2, "same commit green");
        waitLed(3'h4, "same commit red");
        chkBit(erases == 1, 1'b1, "same type no erase");
        chkBit(diskLocal, 1'b0, "still removable");
    endtask : t_removable
    // Switch back to local: second erase and lockout
    task automatic t_local();
        pulse(0);
        waitLed(3'h1, "admin fourth");
        selectCode(0, 1);
        waitLed(3'h2, "local commit green");
        chkBit(erases == 2, 1'b1, "erase again");
        chkBit(diskLocal, 1'b1, "back to local");
        chkBit(usable, 1'b0, "lockout again");
        waitLed(3'h4, "local reset red");
        pulse(1);
        chkBit(unlocked, 1'b0, "unlock refused again");
        chkLed(3'h4, "still standby");
    endtask : t_local

    initial begin
        errors      = 0;
        cmp_count   = 0;
        cycles      = 0;
        erases      = 0;
        rst_n       = 1'b0;
        adminEnter  = 1'b0;
        pinAccept   = 1'b0;
        adminPinSet = 1'b0;
        repeat (12) @(negedge ref_clk);
        rst_n = 1'b1;
        u_op.idle(3);
        t_start();
        t_invalid();
        t_change();
        t_removable();
        t_local();
        results();
    end
endmodule : tb
`default_nettype wire
